// ### rtl/tif_channel.sv
// Overview of operation
// R1 - Input pin passes optional noise filter then edge detector into control. The code drives the edge only to input_edge_out; channel control ignores it.
// R2 - Filter off: input only synchronised to the operating clock.
// R3 - Filter on: new level passed after two equal consecutive samples.
// R4 - Input unused: filter gets no clock, holds its state.
// R5 - Filter off: software waits two clocks after selecting input before start.
// R6 - Filter on: software waits four clocks after selecting input before start.
// R7 - Interrupt period is count clock period times data plus one.
// R8 - Output toggles at every interrupt, giving a 50% duty square wave.
// R9 - Count register is a down counter stepped by each count clock.
// R10 - First count clock after start trigger loads data into counter.
// R11 - Start load raises interrupt and toggles only when start mode bit set.
// R12 - Counter at zero: next count clock interrupts, toggles and reloads.
// R13 - Data register writable anytime; new value used from next period.
// R14 - Start and stop triggers self-clear; start sets enable status.
// R15 - Stop clears enable, freezes counter, holds output level.
// R16 - Output enable clear: written output level drives the pin.
// R17 - Software changes no mode, output mode or polarity while running.
// R18 - Counter readable anytime; status register unused in this mode. The code returns the running state (state not idle) in status bit 0.
// R19 - Software sets output mode, polarity and default level before enabling.
// R20 - Unit enable clear initialises all channel registers and output.
// R21 - Unit disabled ignores register writes; enabling permits writes.
// R22 - Operating clock selectable from four prescaled clock sources.
module tif_channel #(
	parameter int PS_MAX = 16
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// AXI4-Lite write address and data
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	// Timer pins
	input  wire logic        timer_input_pin_in,
	output logic             timer_output_pin_out,
	output logic             timer_output_pin_oe_out,
	output logic             channel_interrupt_out,
	output logic             input_edge_out
);
	import tif_pkg::*;

	// ********************************************************************
	// State
	// ********************************************************************
	typedef struct packed {
		logic                 aw_got;
		logic                 w_got;
		tif_wr_s              wr;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
		logic                 unit_en;
		logic                 nf_en;
		logic [15:0]          mode;
		logic [TIF_CNT_W-1:0] data;
		logic [TIF_CNT_W-1:0] count;
		logic [1:0]           trig;
		logic                 out_level;
		logic                 out_en;
		logic                 out_mode;
		logic                 out_pol;
		logic [3:0][TIF_PS_W-1:0] presc;
		logic [3:0][TIF_PS_W-1:0] pcnt;
		tif_state_e           state;
		logic                 irq;
		tif_in_s              in;
		logic                 edge_q;
	} tif_all_s;

	tif_all_s s_q;
	tif_all_s s_d;

	logic [3:0] ps_tick;
	logic       cclk;
	logic       in_used;
	logic       wr_fire;
	logic       st_wr;
	logic       sp_wr;

	// Input is used when any input-selection mode bit is set
	function automatic logic f_in_used(input logic [15:0] m);
		return m[TIF_CCS_BIT] | m[TIF_STS1_BIT] | m[TIF_STS0_BIT];
	endfunction

	// ********************************************************************
	// Prescaled clock sources
	// ********************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ps
			assign ps_tick[gi] = s_q.unit_en &&
				(s_q.pcnt[gi] == s_q.presc[gi]); // [R22]
		end
	endgenerate

	assign cclk    = ps_tick[s_q.mode[TIF_CKS_LO +: 2]]; // [R22]
	assign in_used = f_in_used(s_q.mode);
	assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
	assign st_wr   = wr_fire && s_q.unit_en && s_q.wr.addr == TIF_ADDR_TRIG
		&& s_q.wr.data[TIF_TRIG_START];
	assign sp_wr   = wr_fire && s_q.unit_en && s_q.wr.addr == TIF_ADDR_TRIG
		&& s_q.wr.data[TIF_TRIG_STOP];

	// ********************************************************************
	// Next state
	// ********************************************************************
	always_comb begin
		s_d     = s_q;
		s_d.irq = 1'b0;

		// Bus write channel: take address and data in either order
		if (s_axi_awvalid_in && !s_q.aw_got) begin
			s_d.aw_got  = 1'b1;
			s_d.wr.addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && !s_q.w_got) begin
			s_d.w_got   = 1'b1;
			s_d.wr.data = s_axi_wdata_in;
		end
		if (s_q.bvalid && s_axi_bready_in) begin
			s_d.bvalid = 1'b0;
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
		end
		s_d.trig = 2'b00; // [R14]
		if (wr_fire) begin
			s_d.bvalid = 1'b1;
			s_d.bresp  = TIF_RESP_OKAY;
			unique case (s_q.wr.addr)
				TIF_ADDR_UNIT: begin
					s_d.unit_en = s_q.wr.data[TIF_UNIT_EN_BIT];
					if (s_q.unit_en)
						s_d.nf_en = s_q.wr.data[TIF_NF_EN_BIT];
				end
				TIF_ADDR_MODE: if (s_q.unit_en)
					s_d.mode = s_q.wr.data[15:0]; // [R21]
				TIF_ADDR_DATA: if (s_q.unit_en)
					s_d.data = s_q.wr.data[TIF_CNT_W-1:0]; // [R13]
				TIF_ADDR_TRIG: if (s_q.unit_en)
					s_d.trig = s_q.wr.data[1:0];
				TIF_ADDR_OUTCTL: if (s_q.unit_en) begin
					if (!s_q.out_en && !s_q.wr.data[TIF_OUT_EN])
						s_d.out_level = s_q.wr.data[TIF_OUT_LEVEL]; // [R16]
					else if (!s_q.out_en)
						s_d.out_level = s_q.wr.data[TIF_OUT_LEVEL];
					s_d.out_en   = s_q.wr.data[TIF_OUT_EN];
					s_d.out_mode = s_q.wr.data[TIF_OUT_MODE];
					s_d.out_pol  = s_q.wr.data[TIF_OUT_POL];
				end
				TIF_ADDR_PRESC: if (s_q.unit_en)
					for (int i = 0; i < 4; i++)
						s_d.presc[i] = s_q.wr.data[i*8 +: TIF_PS_W];
				TIF_ADDR_COUNT, TIF_ADDR_STATUS: ;
				default: s_d.bresp = TIF_RESP_SLVERR;
			endcase
		end

		// Bus read channel
		if (s_q.rvalid && s_axi_rready_in)
			s_d.rvalid = 1'b0;
		if (s_axi_arvalid_in && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = TIF_RESP_OKAY;
			s_d.rdata  = TIF_ZERO32;
			unique case (s_axi_araddr_in)
				TIF_ADDR_UNIT: begin
					s_d.rdata[TIF_UNIT_EN_BIT] = s_q.unit_en;
					s_d.rdata[TIF_NF_EN_BIT]   = s_q.nf_en;
				end
				TIF_ADDR_MODE:  s_d.rdata[15:0] = s_q.mode;
				TIF_ADDR_DATA:  s_d.rdata[TIF_CNT_W-1:0] = s_q.data;
				TIF_ADDR_COUNT: s_d.rdata[TIF_CNT_W-1:0] = s_q.count; // [R18]
				TIF_ADDR_TRIG:  s_d.rdata[1:0] = s_q.trig; // [R14]
				TIF_ADDR_OUTCTL: begin
					s_d.rdata[TIF_OUT_LEVEL] = s_q.out_level;
					s_d.rdata[TIF_OUT_EN]    = s_q.out_en;
					s_d.rdata[TIF_OUT_MODE]  = s_q.out_mode;
					s_d.rdata[TIF_OUT_POL]   = s_q.out_pol;
				end
				TIF_ADDR_STATUS:
					s_d.rdata[0] = (s_q.state != TIF_ST_IDLE); // [R18]
				TIF_ADDR_PRESC:
					for (int i = 0; i < 4; i++)
						s_d.rdata[i*8 +: TIF_PS_W] = s_q.presc[i];
				default: s_d.rresp = TIF_RESP_SLVERR;
			endcase
		end

		// Prescalers
		for (int i = 0; i < 4; i++)
			s_d.pcnt[i] = ps_tick[i] ? '0 : s_q.pcnt[i] + 1'b1;

		// Input conditioning, raw sample taken every cycle, later stages clocked only when the input is used
		s_d.in.raw = timer_input_pin_in;
		if (in_used) begin // [R4]
			s_d.in.sync1 = s_q.in.raw;
			s_d.in.sync2 = s_q.in.sync1;
			if (!s_q.nf_en)
				s_d.in.filt = s_q.in.sync1; // [R2]
			else if (s_q.in.sync1 == s_q.in.sync2)
				s_d.in.filt = s_q.in.sync2; // [R3]
			s_d.in.prev = s_q.in.filt;
		end
		s_d.edge_q = in_used && (s_q.in.filt != s_q.in.prev); // [R1]

		// Channel control
		unique case (s_q.state)
			TIF_ST_IDLE: if (st_wr)
				s_d.state = TIF_ST_ARMED; // [R14]
			TIF_ST_ARMED: if (sp_wr)
				s_d.state = TIF_ST_IDLE;
			else if (cclk) begin
				s_d.count = s_q.data; // [R10]
				s_d.state = TIF_ST_RUN;
				if (s_q.mode[TIF_MD0_BIT]) begin // [R11]
					s_d.irq = 1'b1;
					if (s_q.out_en)
						s_d.out_level = ~s_q.out_level;
				end
			end
			TIF_ST_RUN: if (sp_wr)
				s_d.state = TIF_ST_IDLE; // [R15]
			else if (st_wr)
				s_d.state = TIF_ST_ARMED;
			else if (cclk) begin
				if (s_q.count == TIF_CNT_ZERO) begin
					s_d.count = s_q.data; // [R12] [R13]
					s_d.irq   = 1'b1; // [R7]
					if (s_q.out_en)
						s_d.out_level = ~s_q.out_level; // [R8]
				end else begin
					s_d.count = s_q.count - 1'b1; // [R9]
				end
			end
		endcase

		// Unit disable initialises the channel registers; bus and input conditioning state are kept
		if (!s_q.unit_en) begin // [R20]
			s_d.mode      = TIF_MODE_RST;
			s_d.data      = TIF_CNT_ZERO;
			s_d.count     = TIF_CNT_ZERO;
			s_d.out_level = 1'b0;
			s_d.out_en    = 1'b0;
			s_d.out_mode  = 1'b0;
			s_d.out_pol   = 1'b0;
			s_d.nf_en     = 1'b0;
			s_d.state     = TIF_ST_IDLE;
			s_d.irq       = 1'b0;
			for (int i = 0; i < 4; i++) begin
				s_d.presc[i] = '0;
				s_d.pcnt[i]  = '0;
			end
			if (wr_fire && s_q.wr.addr == TIF_ADDR_UNIT)
				s_d.unit_en = s_q.wr.data[TIF_UNIT_EN_BIT]; // [R21]
		end
	end

	// ********************************************************************
	// Registers
	// ********************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_q.aw_got    <= 1'b0;
			s_q.w_got     <= 1'b0;
			s_q.wr        <= '0;
			s_q.bvalid    <= 1'b0;
			s_q.bresp     <= TIF_RESP_OKAY;
			s_q.rvalid    <= 1'b0;
			s_q.rdata     <= TIF_ZERO32;
			s_q.rresp     <= TIF_RESP_OKAY;
			s_q.unit_en   <= 1'b0;
			s_q.nf_en     <= 1'b0;
			s_q.mode      <= TIF_MODE_RST;
			s_q.data      <= TIF_CNT_ZERO;
			s_q.count     <= TIF_CNT_ZERO;
			s_q.trig      <= 2'b00;
			s_q.out_level <= 1'b0;
			s_q.out_en    <= 1'b0;
			s_q.out_mode  <= 1'b0;
			s_q.out_pol   <= 1'b0;
			s_q.presc     <= '0;
			s_q.pcnt      <= '0;
			s_q.state     <= TIF_ST_IDLE;
			s_q.irq       <= 1'b0;
			s_q.in        <= '0;
			s_q.edge_q    <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	assign s_axi_awready_out       = !s_q.aw_got;
	assign s_axi_wready_out        = !s_q.w_got;
	assign s_axi_bvalid_out        = s_q.bvalid;
	assign s_axi_bresp_out         = s_q.bresp;
	assign s_axi_arready_out       = !s_q.rvalid;
	assign s_axi_rvalid_out        = s_q.rvalid;
	assign s_axi_rdata_out         = s_q.rdata;
	assign s_axi_rresp_out         = s_q.rresp;
	assign timer_output_pin_out    = s_q.out_level;
	assign timer_output_pin_oe_out = s_q.unit_en; // [R16] [R20]
	assign channel_interrupt_out   = s_q.irq;
	assign input_edge_out          = s_q.edge_q;

	// ********************************************************************
	// Checks
	// ********************************************************************
	sequence s_zero_tick;
		s_q.state == TIF_ST_RUN && cclk && s_q.count == TIF_CNT_ZERO
			&& !sp_wr && !st_wr && s_q.unit_en;
	endsequence

	property p_reload;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_zero_tick |=> channel_interrupt_out && s_q.count == $past(s_q.data);
	endproperty
	a_reload: assert property (p_reload) else $error("no reload at zero"); // [R12]

	property p_down;
		@(posedge clk_in) disable iff (!rst_n_in)
		(s_q.state == TIF_ST_RUN && cclk && s_q.count != TIF_CNT_ZERO
			&& !sp_wr && !st_wr && s_q.unit_en)
			|=> s_q.count == $past(s_q.count) - 1'b1;
	endproperty
	a_down: assert property (p_down) else $error("count did not step"); // [R9]

	property p_toggle;
		@(posedge clk_in) disable iff (!rst_n_in)
		(s_zero_tick and s_q.out_en) |=>
			timer_output_pin_out != $past(timer_output_pin_out);
	endproperty
	a_toggle: assert property (p_toggle) else $error("no toggle"); // [R8]

	property p_start_load;
		@(posedge clk_in) disable iff (!rst_n_in)
		(s_q.state == TIF_ST_ARMED && cclk && !sp_wr && s_q.unit_en) |=>
			s_q.count == $past(s_q.data)
			&& channel_interrupt_out == $past(s_q.mode[TIF_MD0_BIT]);
	endproperty
	a_start_load: assert property (p_start_load) else $error("bad load"); // [R10] [R11]

	property p_stop;
		@(posedge clk_in) disable iff (!rst_n_in)
		(sp_wr && s_q.state == TIF_ST_RUN && s_q.unit_en) |=>
			s_q.state == TIF_ST_IDLE ##1 s_q.count == $past(s_q.count, 2);
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not freeze"); // [R15]

	property p_start;
		@(posedge clk_in) disable iff (!rst_n_in)
		(st_wr && s_q.state == TIF_ST_IDLE) |=> s_q.state == TIF_ST_ARMED;
	endproperty
	a_start: assert property (p_start) else $error("start ignored"); // [R14]

	property p_filter;
		@(posedge clk_in) disable iff (!rst_n_in)
		(in_used && s_q.nf_en && s_q.in.sync1 != s_q.in.sync2 && s_q.unit_en)
			|=> s_q.in.filt == $past(s_q.in.filt);
	endproperty
	a_filter: assert property (p_filter) else $error("filter passed glitch"); // [R3]

	property p_unused;
		@(posedge clk_in) disable iff (!rst_n_in)
		!in_used |=> $stable(s_q.in.filt) && !input_edge_out;
	endproperty
	a_unused: assert property (p_unused) else $error("unused filter moved"); // [R4]

	property p_disable;
		@(posedge clk_in) disable iff (!rst_n_in)
		(!s_q.unit_en && !(wr_fire && s_q.wr.addr == TIF_ADDR_UNIT))
			|=> !timer_output_pin_out && !timer_output_pin_oe_out
			&& s_q.count == TIF_CNT_ZERO;
	endproperty
	a_disable: assert property (p_disable) else $error("not initialised"); // [R20]
endmodule

// ### rtl/tif_pkg.sv
package tif_pkg;

	// ********************************************************************
	// Register map (byte addresses)
	// ********************************************************************
	localparam logic [7:0] TIF_ADDR_UNIT    = 8'h00;
	localparam logic [7:0] TIF_ADDR_MODE    = 8'h04;
	localparam logic [7:0] TIF_ADDR_DATA    = 8'h08;
	localparam logic [7:0] TIF_ADDR_COUNT   = 8'h0C;
	localparam logic [7:0] TIF_ADDR_TRIG    = 8'h10;
	localparam logic [7:0] TIF_ADDR_OUTCTL  = 8'h14;
	localparam logic [7:0] TIF_ADDR_STATUS  = 8'h18;
	localparam logic [7:0] TIF_ADDR_PRESC   = 8'h1C;

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int TIF_UNIT_EN_BIT   = 0;
	localparam int TIF_NF_EN_BIT     = 1;
	localparam int TIF_MD0_BIT       = 0;
	localparam int TIF_STS0_BIT      = 8;
	localparam int TIF_STS1_BIT      = 9;
	localparam int TIF_CCS_BIT       = 12;
	localparam int TIF_CKS_LO        = 14;
	localparam int TIF_TRIG_START    = 0;
	localparam int TIF_TRIG_STOP     = 1;
	localparam int TIF_OUT_LEVEL     = 0;
	localparam int TIF_OUT_EN        = 1;
	localparam int TIF_OUT_MODE      = 2;
	localparam int TIF_OUT_POL       = 3;
	localparam int TIF_PS_W          = 4;

	// ********************************************************************
	// Widths and resets
	// ********************************************************************
	localparam int TIF_CNT_W                 = 16;
	localparam logic [15:0] TIF_CNT_ZERO     = 16'h0000;
	localparam logic [15:0] TIF_MODE_RST     = 16'h0000;
	localparam logic [31:0] TIF_ZERO32       = 32'h0000_0000;
	localparam logic [1:0]  TIF_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  TIF_RESP_SLVERR  = 2'h2;

	typedef enum logic [2:0] {
		TIF_ST_IDLE  = 3'h1,
		TIF_ST_ARMED = 3'h2,
		TIF_ST_RUN   = 3'h4
	} tif_state_e;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] data;
	} tif_wr_s;

	typedef struct packed {
		logic       raw;
		logic       sync1;
		logic       sync2;
		logic       filt;
		logic       prev;
	} tif_in_s;

endpackage

// ### testbench/tif_pin_partner.sv
module tif_pin_partner (
	// Clock
	input  wire logic clk_in,
	// Channel output pin
	input  wire logic out_level_in,
	input  wire logic out_oe_in,
	// Line levels
	output logic      pin_src_out,
	output logic      load_level_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import tif_pkg::*;

	logic src_q;
	logic last_q;

	initial src_q = 1'b0;
	initial last_q = 1'b0;

	assign pin_src_out = src_q;
	// Released line shows the inverse of its last driven level
	assign load_level_out = out_oe_in ? out_level_in : ~last_q;

	always @(posedge clk_in) begin
		if (out_oe_in === 1'b1)
			last_q <= out_level_in;
	end

	// Input pulse of n operating clock cycles
	task automatic pulse(input int n);
		@(posedge clk_in);
		src_q <= ~src_q;
		repeat (n) @(posedge clk_in);
		src_q <= ~src_q;
	endtask
endmodule

// ### testbench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tif_pkg::*;

	logic        clk_in, rst_n_in, aw_v, aw_r, w_v, w_r, b_v, b_r;
	logic        ar_v, ar_r, r_v, r_r, pin_i, pin_o, pin_oe, irq, edg;
	logic        load;
	logic [7:0]  aw_a, ar_a;
	logic [31:0] w_d, r_d, rdv, seed, cnt0;
	logic [1:0]  b_q, r_q, rsp;
	int          fail_count, checked, cyc, last_irq, first_irq, edges;
	int          irq_n, t0, d, p, lvl;
	int          iv[$];

	tif_channel DUT (
		.clk_in(clk_in), .rst_n_in(rst_n_in),
		.s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v),
		.s_axi_awready_out(aw_r), .s_axi_wdata_in(w_d),
		.s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(w_v),
		.s_axi_wready_out(w_r), .s_axi_bresp_out(b_q),
		.s_axi_bvalid_out(b_v), .s_axi_bready_in(b_r),
		.s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
		.s_axi_arready_out(ar_r), .s_axi_rdata_out(r_d),
		.s_axi_rresp_out(r_q), .s_axi_rvalid_out(r_v),
		.s_axi_rready_in(r_r), .timer_input_pin_in(pin_i),
		.timer_output_pin_out(pin_o), .timer_output_pin_oe_out(pin_oe),
		.channel_interrupt_out(irq), .input_edge_out(edg)
	);

	tif_pin_partner PEER (
		.clk_in(clk_in), .out_level_in(pin_o), .out_oe_in(pin_oe),
		.pin_src_out(pin_i), .load_level_out(load)
	);

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// ****************************************************************
	// Interrupt and edge monitor
	// ****************************************************************
	always @(posedge clk_in) begin
		cyc++;
		if (edg === 1'b1)
			edges++;
		if (irq === 1'b1) begin
			irq_n++;
			if (first_irq == 0)
				first_irq = cyc;
			iv.push_back(cyc - last_irq);
			last_irq = cyc;
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		int n;
		aw_a <= a;
		w_d <= dat;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk_in);
			if (aw_r === 1'b1)
				aw_v <= 1'b0;
			if (w_r === 1'b1)
				w_v <= 1'b0;
			if (b_v === 1'b1)
				break;
		end
		rsp = b_q;
		b_r <= 1'b0;
		if (n == 64) begin
			fail_count++;
			close_out();
		end else
			@(posedge clk_in);
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge clk_in);
			if (ar_r === 1'b1)
				ar_v <= 1'b0;
			if (r_v === 1'b1)
				break;
		end
		rdv = r_d;
		rsp = r_q;
		r_r <= 1'b0;
		if (n == 64) begin
			fail_count++;
			close_out();
		end else
			@(posedge clk_in);
	endtask

	// Start, run four periods, stop, compare with the period model
	task automatic run(input int md0);
		int per;
		int f;
		per = (d + 1) * (p + 1);
		iv.delete();
		irq_n = 0;
		first_irq = 0;
		lvl = load;
		t0 = cyc;
		wr(TIF_ADDR_TRIG, 32'h0000_0001);
		rd(TIF_ADDR_TRIG);
		chk(rdv, TIF_ZERO32);
		rd(TIF_ADDR_STATUS);
		chk(rdv, 32'h0000_0001);
		idle(4 * per + 8);
		wr(TIF_ADDR_TRIG, 32'h0000_0002);
		rd(TIF_ADDR_STATUS);
		chk(rdv, TIF_ZERO32);
		rd(TIF_ADDR_COUNT);
		cnt0 = rdv;
		chk(32'(cnt0 <= 32'(d)), 32'h1);
		chk(32'(load), 32'(lvl ^ (irq_n & 1)));
		lvl = load;
		idle(per + 4);
		rd(TIF_ADDR_COUNT);
		chk(rdv, cnt0);
		chk(32'(load), 32'(lvl));
		f = first_irq - t0;
		chk(32'(md0 ? f <= p + 10 : f > per && f <= per + p + 10), 1);
		for (int i = 1; i < iv.size(); i++)
			chk(32'(iv[i]), 32'(per));
	endtask

	task automatic filt(input int n, input int exp);
		edges = 0;
		PEER.pulse(n);
		idle(8);
		chk(32'(edges), 32'(exp));
	endtask

	initial begin
		seed = 32'h0000_0060;
		rst_n_in = 1'b0;
		{aw_v, w_v, b_r, ar_v, r_r} = '0;
		{aw_a, ar_a, w_d} = '0;
		idle(20);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		wr(TIF_ADDR_DATA, 32'h0000_0055);
		rd(TIF_ADDR_DATA);
		chk(rdv, TIF_ZERO32);
		rd(8'h20);
		chk(32'(rsp), 32'(TIF_RESP_SLVERR));
		wr(8'h24, TIF_ZERO32);
		chk(32'(rsp), 32'(TIF_RESP_SLVERR));
		wr(TIF_ADDR_UNIT, 32'h0000_0001);
		wr(TIF_ADDR_DATA, 32'h0000_0055);
		rd(TIF_ADDR_DATA);
		chk(rdv, 32'h0000_0055);
		$display("test register access done");
		wr(TIF_ADDR_OUTCTL, 32'h0000_0001);
		idle(2);
		chk(32'(pin_o), 32'h1);
		chk(32'(pin_oe), 32'h1);
		wr(TIF_ADDR_OUTCTL, 32'h0000_0003);
		idle(2);
		chk(32'(load), 32'h1);
		$display("test output level done");
		for (int k = 0; k < 4; k++) begin
			p = rnd() & 3;
			d = rnd() & 7;
			wr(TIF_ADDR_PRESC, 32'(p) << (8 * k));
			wr(TIF_ADDR_MODE, (32'(k) << TIF_CKS_LO) | 32'h1);
			wr(TIF_ADDR_DATA, 32'(d));
			run(1);
		end
		$display("test interval sources done");
		p = 0;
		d = 5;
		wr(TIF_ADDR_PRESC, TIF_ZERO32);
		wr(TIF_ADDR_MODE, TIF_ZERO32);
		wr(TIF_ADDR_DATA, 32'(d));
		run(0);
		iv.delete();
		wr(TIF_ADDR_TRIG, 32'h0000_0001);
		idle(20);
		wr(TIF_ADDR_DATA, 32'h0000_0002);
		idle(20);
		wr(TIF_ADDR_TRIG, 32'h0000_0002);
		chk(32'(iv[1]), 32'h6);
		chk(32'(iv[$]), 32'h3);
		$display("test data rewrite done");
		filt(3, 0);
		wr(TIF_ADDR_MODE, 32'h0000_1000);
		idle(2);
		filt(1, 2);
		wr(TIF_ADDR_UNIT, 32'h0000_0003);
		idle(4);
		filt(1, 0);
		filt(3, 2);
		$display("test input filter done");
		wr(TIF_ADDR_UNIT, TIF_ZERO32);
		idle(2);
		chk(32'({pin_o, pin_oe}), 32'h0);
		wr(TIF_ADDR_UNIT, 32'h0000_0001);
		rd(TIF_ADDR_DATA);
		chk(rdv, TIF_ZERO32);
		rd(TIF_ADDR_OUTCTL);
		chk(rdv, TIF_ZERO32);
		$display("test unit disable done");
		close_out();
	end
endmodule
